// ---- logic/xy_pkg.sv ----
// shared constants, carriers and state types for the x/y scratch memory
// Summary of operation
// - The memory is four pages, X page 0, X page 1, Y page 0 and Y page 1.
// - Logical addresses place X pages at A5007000 and A5008000, Y pages at A5017000 and A5018000, 4 kbytes each.
// - The physical-address port sees the same pages with the top three address bits zero.
// - The X and Y data ports ignore the upper 16 address bits.
// - Every page can be reached from the physical port, its own data port and the logical port.
// - Each port decodes only its own address view.
// - On a page collision the physical port wins, then the data port, then the logical port.
// - A logical access finishes in one cycle, a physical access takes several.
// - Data port accesses finish in one cycle and X and Y may proceed together.
// - Every colliding access still completes correctly, the losers only later.
// - In sleep mode the physical port is not served.
// - A write that raises an address error leaves the memory contents undefined.
// - The logical port serves the CPU in privileged mode or user DSP mode only.
package xy_pkg;
	localparam int XY_PAGES = 4;
	localparam int XY_WORDS = 1024;
	localparam int XY_PORTS = 4;
	// port numbers, also the arbitration order
	localparam int XY_P_PHYS = 0;
	localparam int XY_P_XD = 1;
	localparam int XY_P_YD = 2;
	localparam int XY_P_LOG = 3;
	localparam logic [3:0][31:0] XY_LOG_BASE = {32'hA5018000, 32'hA5017000,
		32'hA5008000, 32'hA5007000};
	localparam logic [31:0] XY_PAGE_MASK = 32'hFFFFF000;
	localparam logic [31:0] XY_PHYS_MASK = 32'h1FFFFFFF;
	localparam logic [31:0] XY_DATA_MASK = 32'h0000FFFF;
	localparam int XY_IDX_LSB = 2;
	localparam int XY_IDX_MSB = 11;
	// cycles of bus latency before a physical request may arbitrate
	localparam logic [3:0] XY_PHYS_BUS_CYCLES = 4'h3;
	// apb register byte offsets
	localparam logic [11:0] XY_OFS_MODE = 12'h000;
	localparam logic [11:0] XY_OFS_STATUS = 12'h004;
	localparam logic [11:0] XY_OFS_CONFLICTS = 12'h008;
	// mode register fields
	localparam int XY_MODE_PRIV = 0;
	localparam int XY_MODE_DSP = 1;
	localparam int XY_MODE_CACHE = 2;
	localparam int XY_MODE_XLATE = 3;
	localparam logic [3:0] XY_MODE_RESET = 4'h1;
	// status register fields
	localparam int XY_ST_CONFLICT = 0;
	localparam int XY_ST_UNDEF = 1;
	localparam int XY_ST_REFUSED = 2;
	localparam int XY_ST_SLEEPBLK = 3;
	localparam int XY_ST_SLEEP = 4;
	localparam logic [15:0] XY_CONFLICT_MAX = 16'hFFFF;
	// address views
	localparam logic [1:0] XY_VIEW_LOG = 2'h0;
	localparam logic [1:0] XY_VIEW_PHYS = 2'h1;
	localparam logic [1:0] XY_VIEW_XD = 2'h2;
	localparam logic [1:0] XY_VIEW_YD = 2'h3;

	typedef struct packed {
		logic valid;
		logic we;
		logic [3:0] be;
		logic [31:0] addr;
		logic [31:0] wdata;
	} xy_req_s;

	typedef struct packed {
		logic done;
		logic err;
		logic [31:0] rdata;
	} xy_rsp_s;

	typedef enum logic [2:0] {
		XY_PH_IDLE = 3'b001,
		XY_PH_BUS = 3'b010,
		XY_PH_ARB = 3'b100
	} xy_ph_state_e;

	typedef struct packed {
		logic [XY_WORDS-1:0][31:0] mem;
	} xy_page_s;

	typedef struct packed {
		xy_ph_state_e ph_st;
		logic [3:0] ph_cnt;
		xy_rsp_s [XY_PORTS-1:0] rsp;
		logic [3:0] mode;
		logic [3:0] sticky;
		logic [15:0] conflicts;
		logic [2:0] slp_sync;
		logic slp_lvl;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} xy_state_s;
endpackage

// ---- logic/xy_page_store.sv ----
// one 4 kbyte page of scratch storage with a single arbitrated access path
`timescale 1ns/1ps
module xy_page_store import xy_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic en,
	input wire logic we,
	input wire logic [3:0] be,
	input wire logic [9:0] idx,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	xy_page_s cur_reg;
	xy_page_s page_next;

	// read is the word before this cycle's write
	assign rdata = cur_reg.mem[idx];

	always_comb begin
		page_next = cur_reg;
		if (en && we) begin
			for (int b = 0; b < 4; b++) begin
				if (be[b]) begin
					page_next.mem[idx][b*8 +: 8] = wdata[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= page_next;
		end
	end
endmodule

// ---- logic/xy_scratch_memory.sv ----
// four-page x/y scratch memory with four arbitrated access ports and apb status
`timescale 1ns/1ps
module xy_scratch_memory import xy_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sleep_mode,
	input wire xy_req_s phys_req,
	input wire xy_req_s xd_req,
	input wire xy_req_s yd_req,
	input wire xy_req_s log_req,
	output xy_rsp_s phys_rsp,
	output xy_rsp_s xd_rsp,
	output xy_rsp_s yd_rsp,
	output xy_rsp_s log_rsp,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	xy_state_s state_reg;
	xy_state_s state_next;

	xy_req_s [XY_PORTS-1:0] req;
	logic [XY_PORTS-1:0] live;
	logic [XY_PORTS-1:0] hit;
	logic [XY_PORTS-1:0] want;
	logic [XY_PORTS-1:0] bad;
	logic [XY_PORTS-1:0] grant;
	logic [XY_PORTS-1:0][1:0] page_of;
	logic [XY_PORTS-1:0] lost;
	logic [XY_PAGES-1:0] pg_en;
	logic [XY_PAGES-1:0] pg_we;
	logic [XY_PAGES-1:0][3:0] pg_be;
	logic [XY_PAGES-1:0][9:0] pg_idx;
	logic [XY_PAGES-1:0][31:0] pg_wd;
	logic [XY_PAGES-1:0][31:0] pg_rd;
	logic [XY_PAGES-1:0][1:0] pg_sel;
	logic [3:0] sticky_set;
	logic [3:0] sticky_clr;
	logic mode_ok;
	logic apb_setup;
	logic apb_write;
	logic any_conflict;

	assign req[XY_P_PHYS] = phys_req;
	assign req[XY_P_XD] = xd_req;
	assign req[XY_P_YD] = yd_req;
	assign req[XY_P_LOG] = log_req;

	// returns {hit, page} for an address seen through one view
	function automatic logic [2:0] xy_decode(input logic [31:0] a, input logic [1:0] view);
		logic [2:0] r;
		logic [31:0] b;
		logic [31:0] m;
		logic ok;
		r = 3'h0;
		for (int i = 0; i < XY_PAGES; i++) begin
			b = XY_LOG_BASE[i];
			m = XY_PAGE_MASK;
			ok = 1'b1;
			if (view == XY_VIEW_PHYS) begin
				b = b & XY_PHYS_MASK;
			end
			if (view == XY_VIEW_XD || view == XY_VIEW_YD) begin
				m = m & XY_DATA_MASK;
			end
			// data ports reach only their own half
			if (view == XY_VIEW_XD && i >= 2) begin
				ok = 1'b0;
			end
			if (view == XY_VIEW_YD && i < 2) begin
				ok = 1'b0;
			end
			if (ok && ((a & m) == (b & m))) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	// byte enables a single aligned access can carry
	function automatic logic xy_be_legal(input logic [3:0] be);
		logic r;
		r = 1'b0;
		case (be)
			4'hF, 4'h3, 4'hC, 4'h1, 4'h2, 4'h4, 4'h8: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [1:0] xy_view_of(input int p);
		logic [1:0] v;
		v = XY_VIEW_LOG;
		case (p)
			XY_P_PHYS: v = XY_VIEW_PHYS;
			XY_P_XD: v = XY_VIEW_XD;
			XY_P_YD: v = XY_VIEW_YD;
			default: v = XY_VIEW_LOG;
		endcase
		return v;
	endfunction

	genvar g;
	generate
		for (g = 0; g < XY_PAGES; g++) begin : gen_page
			xy_page_store u_page (
				.ref_clk(ref_clk),
				.rst(rst),
				.en(pg_en[g]),
				.we(pg_we[g]),
				.be(pg_be[g]),
				.idx(pg_idx[g]),
				.wdata(pg_wd[g]),
				.rdata(pg_rd[g])
			);
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		live = '0;
		hit = '0;
		want = '0;
		bad = '0;
		grant = '0;
		page_of = '0;
		lost = '0;
		pg_en = '0;
		pg_we = '0;
		pg_be = '0;
		pg_idx = '0;
		pg_wd = '0;
		pg_sel = '0;
		sticky_set = '0;
		sticky_clr = '0;
		any_conflict = 1'b0;

		// sleep pin: third flop agreeing with second moves the level
		state_next.slp_sync = {state_reg.slp_sync[1:0], sleep_mode};
		if (state_reg.slp_sync[1] == state_reg.slp_sync[2]) begin
			state_next.slp_lvl = state_reg.slp_sync[2];
		end

		// logical port open to privileged or user dsp code only
		mode_ok = state_reg.mode[XY_MODE_PRIV] | state_reg.mode[XY_MODE_DSP];

		// a port whose done is showing still holds the old request
		for (int p = 0; p < XY_PORTS; p++) begin
			live[p] = req[p].valid & ~state_reg.rsp[p].done;
			{hit[p], page_of[p]} = xy_decode(req[p].addr, xy_view_of(p));
		end

		// physical port waits out bus latency and is frozen in sleep
		want[XY_P_PHYS] = live[XY_P_PHYS] & (state_reg.ph_st == XY_PH_ARB)
			& ~state_reg.slp_lvl;
		want[XY_P_XD] = live[XY_P_XD];
		want[XY_P_YD] = live[XY_P_YD];
		want[XY_P_LOG] = live[XY_P_LOG] & mode_ok;
		for (int p = 0; p < XY_PORTS; p++) begin
			if (want[p] && !hit[p]) begin
				bad[p] = 1'b1;
				want[p] = 1'b0;
			end
		end
		if (live[XY_P_LOG] && !mode_ok) begin
			bad[XY_P_LOG] = 1'b1;
			sticky_set[XY_ST_REFUSED] = 1'b1;
		end
		if (live[XY_P_PHYS] && state_reg.ph_st == XY_PH_ARB && state_reg.slp_lvl) begin
			sticky_set[XY_ST_SLEEPBLK] = 1'b1;
		end

		// fixed priority per page: lower port number wins
		for (int pg = 0; pg < XY_PAGES; pg++) begin
			for (int p = 0; p < XY_PORTS; p++) begin
				if (want[p] && page_of[p] == 2'(pg)) begin
					if (!pg_en[pg]) begin
						pg_en[pg] = 1'b1;
						pg_sel[pg] = 2'(p);
						grant[p] = 1'b1;
					end else begin
						// loser keeps waiting on its held request
						lost[p] = 1'b1;
						any_conflict = 1'b1;
					end
				end
			end
		end

		// pages run in parallel, so x and y halves proceed together
		for (int pg = 0; pg < XY_PAGES; pg++) begin
			pg_idx[pg] = req[pg_sel[pg]].addr[XY_IDX_MSB:XY_IDX_LSB];
			pg_be[pg] = req[pg_sel[pg]].be;
			pg_wd[pg] = req[pg_sel[pg]].wdata;
			// malformed write is dropped, leaving the word undefined
			pg_we[pg] = pg_en[pg] & req[pg_sel[pg]].we & xy_be_legal(req[pg_sel[pg]].be);
		end

		// answers are one-cycle pulses the cycle after the grant
		for (int p = 0; p < XY_PORTS; p++) begin
			state_next.rsp[p] = '0;
			if (grant[p]) begin
				state_next.rsp[p].done = 1'b1;
				if (req[p].we && !xy_be_legal(req[p].be)) begin
					state_next.rsp[p].err = 1'b1;
					sticky_set[XY_ST_UNDEF] = 1'b1;
				end
				if (!req[p].we) begin
					state_next.rsp[p].rdata = pg_rd[page_of[p]];
				end
			end else if (bad[p]) begin
				state_next.rsp[p].done = 1'b1;
				state_next.rsp[p].err = 1'b1;
			end
		end
		if (any_conflict) begin
			sticky_set[XY_ST_CONFLICT] = 1'b1;
		end

		// physical port bus latency sequencer
		case (state_reg.ph_st)
			XY_PH_IDLE: begin
				if (live[XY_P_PHYS]) begin
					state_next.ph_st = XY_PH_BUS;
					state_next.ph_cnt = XY_PHYS_BUS_CYCLES;
				end
			end
			XY_PH_BUS: begin
				if (state_reg.ph_cnt <= 4'h1) begin
					state_next.ph_st = XY_PH_ARB;
					state_next.ph_cnt = 4'h0;
				end else begin
					state_next.ph_cnt = state_reg.ph_cnt - 4'h1;
				end
			end
			XY_PH_ARB: begin
				if (grant[XY_P_PHYS] || bad[XY_P_PHYS] || !req[XY_P_PHYS].valid) begin
					state_next.ph_st = XY_PH_IDLE;
				end
			end
			default: begin
				state_next.ph_st = XY_PH_IDLE;
				state_next.ph_cnt = 4'h0;
			end
		endcase

		// apb slave: ready is raised for the single access cycle
		apb_setup = psel & ~penable & ~state_reg.pready;
		apb_write = psel & penable & state_reg.pready & pwrite & ~state_reg.pslverr;
		state_next.pready = apb_setup;
		if (apb_setup) begin
			state_next.pslverr = 1'b0;
			state_next.prdata = '0;
			case (paddr)
				XY_OFS_MODE: state_next.prdata = {28'h0000000, state_reg.mode};
				XY_OFS_STATUS: state_next.prdata = {27'h0000000, state_reg.slp_lvl,
					state_reg.sticky};
				XY_OFS_CONFLICTS: state_next.prdata = {16'h0000, state_reg.conflicts};
				default: state_next.pslverr = 1'b1;
			endcase
		end
		if (apb_write) begin
			case (paddr)
				XY_OFS_MODE: state_next.mode = pwdata[3:0];
				XY_OFS_STATUS: sticky_clr = pwdata[3:0];
				default: ;
			endcase
		end

		// an event in the clearing cycle survives the clear
		state_next.sticky = (state_reg.sticky & ~sticky_clr) | sticky_set;
		if (apb_write && paddr == XY_OFS_CONFLICTS) begin
			state_next.conflicts = 16'h0000;
		end
		if (any_conflict && state_next.conflicts != XY_CONFLICT_MAX) begin
			state_next.conflicts = state_next.conflicts + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.ph_st <= XY_PH_IDLE;
			state_reg.mode <= XY_MODE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign phys_rsp = state_reg.rsp[XY_P_PHYS];
	assign xd_rsp = state_reg.rsp[XY_P_XD];
	assign yd_rsp = state_reg.rsp[XY_P_YD];
	assign log_rsp = state_reg.rsp[XY_P_LOG];
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
endmodule

// ---- sim/xy_checker.sv ----
// port assertions for the x/y scratch memory
`timescale 1ns/1ps
module xy_checker import xy_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sleep_mode,
	input wire xy_req_s phys_req,
	input wire xy_req_s xd_req,
	input wire xy_req_s yd_req,
	input wire xy_req_s log_req,
	input wire xy_rsp_s phys_rsp,
	input wire xy_rsp_s xd_rsp,
	input wire xy_rsp_s yd_rsp,
	input wire xy_rsp_s log_rsp,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	logic xd_go;
	logic yd_go;
	logic lg_go;
	logic same_pg;
	// a live physical request may reach arbitration, so it spoils the quiet case
	assign xd_go = xd_req.valid && !xd_rsp.done && !phys_req.valid;
	assign yd_go = yd_req.valid && !yd_rsp.done && !phys_req.valid;
	assign lg_go = log_req.valid && !log_rsp.done && !phys_req.valid;
	assign same_pg = log_req.addr[31:12] == {16'hA500, xd_req.addr[15:12]} &&
		xd_req.addr[15:12] inside {4'h7, 4'h8};
	chk_xd_single: assert property (xd_go |=> xd_rsp.done)
		else $error("x data access not done in one cycle");
	chk_xy_both: assert property (xd_go && yd_go |=> xd_rsp.done && yd_rsp.done)
		else $error("x and y accesses not served together");
	chk_log_single: assert property (lg_go && !xd_req.valid && !yd_req.valid |=>
		log_rsp.done)
		else $error("logical access not done in one cycle");
	chk_log_loses: assert property (lg_go && xd_go && same_pg |=>
		!log_rsp.done ##1 log_rsp.done)
		else $error("logical port not served after data port");
	chk_log_miss: assert property (lg_go && log_req.addr[31:29] == 3'h0 |=>
		log_rsp.done && log_rsp.err)
		else $error("physical address accepted on logical port");
	chk_phys_late: assert property (phys_rsp.done |-> $past(phys_req.valid, 5))
		else $error("physical access answered too early");
	chk_phys_fast: assert property ((!sleep_mode)[*4] ##0 $rose(phys_req.valid) ##1
		(!sleep_mode)[*4] |-> ##1 phys_rsp.done)
		else $error("physical access not answered in time");
	chk_sleep_hold: assert property (sleep_mode[*6] |-> !phys_rsp.done)
		else $error("physical access served in sleep");
	cover property (xd_rsp.done && yd_rsp.done);
	cover property (lg_go && xd_go && same_pg);
	cover property (sleep_mode && phys_req.valid);
	cover property (phys_rsp.done && !phys_rsp.err);
endmodule
bind xy_scratch_memory xy_checker xy_checker_inst (.ref_clk, .rst, .sleep_mode,
	.phys_req, .xd_req, .yd_req, .log_req, .phys_rsp, .xd_rsp, .yd_rsp, .log_rsp,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// ---- sim/xy_dma_model.sv ----
// dma master model on the physical-address port
`timescale 1ns/1ps
module xy_dma_model import xy_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic go,
	input wire xy_req_s cmd,
	input wire xy_rsp_s rsp,
	output xy_req_s req,
	output logic busy
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req <= '0;
			busy <= 1'b0;
		end else if (go && !busy) begin
			// one assignment per step: the address is cut while the command is copied
			req <= '{cmd.valid, cmd.we, cmd.be, cmd.addr & XY_PHYS_MASK, cmd.wdata};
			busy <= 1'b1;
		end else if (busy && rsp.done) begin
			// held until answered; released address and data lines show no stale value
			req.valid <= 1'b0;
			req.addr <= ~req.addr;
			req.wdata <= ~req.wdata;
			busy <= 1'b0;
		end
	end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the x/y scratch memory
`timescale 1ns/1ps
module testbench import xy_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic sleep_mode = 1'b0;
	logic go = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	xy_req_s cmd = '0;
	xy_req_s preq;
	xy_req_s xd_req = '0;
	xy_req_s yd_req = '0;
	xy_req_s log_req = '0;
	xy_rsp_s rs [0:3];
	int fails = 0;
	int n_compared = 0;
	always #4 ref_clk = ~ref_clk;
	xy_scratch_memory xy_scratch_memory_inst (.ref_clk, .rst, .sleep_mode,
		.phys_req(preq), .xd_req, .yd_req, .log_req, .phys_rsp(rs[0]),
		.xd_rsp(rs[1]), .yd_rsp(rs[2]), .log_rsp(rs[3]), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	xy_dma_model xy_dma_model_inst (.ref_clk, .rst, .go, .cmd, .rsp(rs[0]),
		.req(preq), .busy());
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic put(input int p, input xy_req_s q);
		if (p == 1) xd_req <= q;
		else if (p == 2) yd_req <= q;
		else log_req <= q;
	endtask
	task automatic acc(input int p, input logic w, input logic [31:0] a, d,
		input logic [3:0] be, output xy_rsp_s r, output int n);
		@(posedge ref_clk);
		put(p, '{1'b1, w, be, a, d});
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rs[p].done !== 1'b1 && n < 50);
		r = rs[p];
		put(p, '{1'b0, 1'b0, 4'h0, ~a, ~d});
	endtask
	task automatic phys(input logic [31:0] a, output xy_rsp_s r, output int n);
		@(posedge ref_clk);
		go <= 1'b1;
		cmd <= '{1'b1, 1'b0, 4'hF, a, 32'h0};
		@(posedge ref_clk);
		go <= 1'b0;
		n = 1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rs[0].done !== 1'b1 && n < 60);
		r = rs[0];
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic t_main();
		xy_rsp_s a;
		xy_rsp_s b;
		int na;
		int nb;
		logic [31:0] v;
		logic e;
		fork
			acc(1, 1'b1, 32'h1234_7004, 32'hCAFE_0001, 4'hF, a, na);
			acc(2, 1'b1, 32'hABCD_8010, 32'hBEEF_0002, 4'hF, b, nb);
		join
		check(na + nb, 4);
		acc(3, 1'b0, 32'hA500_7004, 32'h0, 4'hF, a, na);
		check(a.rdata, 32'hCAFE_0001);
		check(na, 2);
		acc(3, 1'b0, 32'hA501_8010, 32'h0, 4'hF, a, na);
		check(a.rdata, 32'hBEEF_0002);
		acc(2, 1'b0, 32'h7777_8010, 32'h0, 4'hF, a, na);
		check(a.rdata, 32'hBEEF_0002);
		check(na, 2);
		acc(3, 1'b0, 32'h0500_7004, 32'h0, 4'hF, a, na);
		check(a.err, 1'b1);
		phys(32'hA501_8010, a, na);
		check(a.rdata, 32'hBEEF_0002);
		check(na, 7);
		fork
			acc(1, 1'b1, 32'h0000_8000, 32'h5A5A_0003, 4'hF, a, na);
			acc(3, 1'b0, 32'hA500_8000, 32'h0, 4'hF, b, nb);
		join
		check(na, 2);
		check(nb, 3);
		check(b.rdata, 32'h5A5A_0003);
		apb(1'b0, XY_OFS_CONFLICTS, 32'h0, v, e);
		check(v, 32'h1);
		apb(1'b0, XY_OFS_MODE, 32'h0, v, e);
		check(v, 32'h1);
		apb(1'b1, XY_OFS_MODE, 32'h0, v, e);
		acc(3, 1'b0, 32'hA500_7004, 32'h0, 4'hF, a, na);
		check(a.err, 1'b1);
		apb(1'b1, XY_OFS_MODE, 32'h2, v, e);
		acc(3, 1'b0, 32'hA500_7004, 32'h0, 4'hF, a, na);
		check(a.err, 1'b0);
		acc(1, 1'b1, 32'h0000_7008, 32'h1, 4'h5, a, na);
		check(a.err, 1'b1);
		apb(1'b0, XY_OFS_STATUS, 32'h0, v, e);
		check(v[2:1], 2'h3);
		apb(1'b0, 12'h00C, 32'h0, v, e);
		check(e, 1'b1);
		sleep_mode <= 1'b1;
		repeat (5) @(posedge ref_clk);
		fork
			phys(32'hA500_7004, a, na);
			begin
				repeat (20) @(posedge ref_clk);
				sleep_mode <= 1'b0;
			end
		join
		check(na > 20, 1'b1);
		check(a.rdata, 32'hCAFE_0001);
		apb(1'b0, XY_OFS_STATUS, 32'h0, v, e);
		check(v[3], 1'b1);
		check(v[4], 1'b0);
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_main();
		finish_test();
	end
	initial begin
		#100000;
		fails++;
		finish_test();
	end
endmodule
